// ---- rtl/rpt_pulse_train.sv ----
// Purpose: Ramped pulse train generator with APB registers and one interrupt
// Assumes: APB master on CLK_IN; request is a 0 to 1 change of the request bit
// Notes:   A run's settings are captured when it starts
//
// Behaviour
// - A run with ramp_enable set, a nonzero slope and a peak above 50 pps ramps up from rest to the peak rate and back down to rest at its end.
// - One slope setting drives both the up ramp and the down ramp.
// - Ramp step n runs at n times 50 pulses per second.
// - Ramp step n emits slope times n pulses.
// - A step therefore lasts slope times 20 ms, exactly via the step rate.
// - The up ramp covers the steps whose rates are below the peak, then the peak rate follows.
// - The down ramp uses the same steps in reverse and the same pulse count.
// - The constant phase emits the total minus both ramp pulse counts.
// - A run whose two ramps need more pulses than the total is refused with an error.
// - Output is either one pulse line plus a direction level, or separate fwd and rev pulses.
// - Peak rates outside 50 to 2000 or not a multiple of 50 are refused with code 02.
// - The ramp error reports code 03 and a normal run code 00.
// - The direction level is low for forward and high for reverse.

`timescale 1ns/1ps

module rpt_pulse_train #(
  parameter int unsigned CLK_HZ = rpt_pkg::CLK_HZ
) (
  // Clock and reset
  input  wire logic        CLK_IN,
  input  wire logic        SYS_RST_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic             PREADY_OUT,
  output logic [31:0]      PRDATA_OUT,
  output logic             PSLVERR_OUT,
  // Motor driver
  output logic             PULSE_OUT,
  output logic             REV_PULSE_OUT,
  output logic             DIR_OUT,
  // Interrupt
  output logic             IRQ_OUT
);

  localparam int ACC_W = 32;
  initial begin
    if (CLK_HZ < 4 * rpt_pkg::MAX_PPS || CLK_HZ > 32'hFFFF_0000) begin
      $error("rpt_pulse_train: CLK_HZ out of range");
    end
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  rpt_pkg::rpt_ctrl_s                ctrl;
  logic [rpt_pkg::RATE_W-1:0]        peak_pulse_rate;
  logic [rpt_pkg::COUNT_W-1:0]       total_pulse_count;
  logic [rpt_pkg::SLOPE_W-1:0]       ramp_slope;
  logic [rpt_pkg::INT_W-1:0]         int_stat;
  logic [rpt_pkg::INT_W-1:0]         int_mask;
  logic [7:0]                        err_code;
  logic                              running;
  logic                              done;
  logic [rpt_pkg::COUNT_W-1:0]       cur_count;
  logic                              req_prev;
  logic                              wr_en;
  logic                              rd_setup;
  logic                              addr_ok;

  assign wr_en    = PSEL_IN && PENABLE_IN && PWRITE_IN;
  assign rd_setup = PSEL_IN && !PENABLE_IN;
  assign PREADY_OUT = 1'b1;
  assign addr_ok  = PADDR_IN inside {rpt_pkg::ADDR_CTRL, rpt_pkg::ADDR_PEAK_RATE,
                                     rpt_pkg::ADDR_TOTAL, rpt_pkg::ADDR_SLOPE,
                                     rpt_pkg::ADDR_STATUS, rpt_pkg::ADDR_CUR_COUNT,
                                     rpt_pkg::ADDR_INT_STAT, rpt_pkg::ADDR_INT_MASK};

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ctrl              <= '0;
      peak_pulse_rate   <= rpt_pkg::RST_PEAK_RATE;
      total_pulse_count <= rpt_pkg::RST_TOTAL;
      ramp_slope        <= rpt_pkg::RST_SLOPE;
      int_mask          <= '0;
    end else if (wr_en) begin
      unique case (PADDR_IN)
        rpt_pkg::ADDR_CTRL:      ctrl              <= PWDATA_IN[3:0];
        rpt_pkg::ADDR_PEAK_RATE: peak_pulse_rate   <= PWDATA_IN[rpt_pkg::RATE_W-1:0];
        rpt_pkg::ADDR_TOTAL:     total_pulse_count <= PWDATA_IN;
        rpt_pkg::ADDR_SLOPE:     ramp_slope        <= PWDATA_IN[rpt_pkg::SLOPE_W-1:0];
        rpt_pkg::ADDR_INT_MASK:  int_mask          <= PWDATA_IN[rpt_pkg::INT_W-1:0];
        default: ;
      endcase
    end
  end

  // Read data is latched in the setup cycle and shown in the access cycle
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PRDATA_OUT  <= '0;
      PSLVERR_OUT <= 1'b0;
    end else if (rd_setup) begin
      PSLVERR_OUT <= !addr_ok;
      PRDATA_OUT  <= '0;
      unique case (PADDR_IN)
        rpt_pkg::ADDR_CTRL:      PRDATA_OUT <= {28'h000_0000, ctrl};
        rpt_pkg::ADDR_PEAK_RATE: PRDATA_OUT <= {20'h0_0000, peak_pulse_rate};
        rpt_pkg::ADDR_TOTAL:     PRDATA_OUT <= total_pulse_count;
        rpt_pkg::ADDR_SLOPE:     PRDATA_OUT <= {16'h0000, ramp_slope};
        rpt_pkg::ADDR_STATUS: begin
          PRDATA_OUT[rpt_pkg::STAT_CODE_LSB +: 8] <= err_code;
          PRDATA_OUT[rpt_pkg::STAT_RUN_BIT]       <= running;
          PRDATA_OUT[rpt_pkg::STAT_DONE_BIT]      <= done;
        end
        rpt_pkg::ADDR_CUR_COUNT: PRDATA_OUT <= cur_count;
        rpt_pkg::ADDR_INT_STAT:  PRDATA_OUT <= {30'h0000_0000, int_stat};
        rpt_pkg::ADDR_INT_MASK:  PRDATA_OUT <= {30'h0000_0000, int_mask};
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Request edge and run validation
  // ---------------------------------------------------------------
  rpt_pkg::rpt_state_e               state;
  rpt_pkg::rpt_run_s                 run;
  rpt_pkg::rpt_run_s                 next_run;
  logic                              start_req;
  logic                              rate_bad;
  logic                              ramp_bad;
  logic [rpt_pkg::COUNT_W-1:0]       tri_steps;
  logic [rpt_pkg::COUNT_W:0]         ramp_pulses;
  logic [rpt_pkg::COUNT_W+1:0]       both_ramps;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      req_prev <= 1'b0;
    end else begin
      req_prev <= ctrl.request;
    end
  end
  assign start_req = ctrl.request && !req_prev && (state == rpt_pkg::ST_IDLE);
  always_comb begin
    next_run                   = '0;
    next_run.ctrl              = ctrl;
    next_run.ramp_slope        = ramp_slope;
    next_run.total_pulse_count = total_pulse_count;
    next_run.peak_step = rpt_pkg::STEP_W'(peak_pulse_rate / rpt_pkg::RATE_W'(rpt_pkg::STEP_PPS));
    rate_bad = (peak_pulse_rate == '0)
            || (peak_pulse_rate > rpt_pkg::RATE_W'(rpt_pkg::MAX_PPS))
            || ((peak_pulse_rate % rpt_pkg::RATE_W'(rpt_pkg::STEP_PPS)) != '0);
    // Steps 1..K-1 lie below the peak: slope * K*(K-1)/2 pulses per ramp
    tri_steps = rpt_pkg::COUNT_W'((32'(next_run.peak_step) *
                (32'(next_run.peak_step) - 32'h0000_0001)) >> 1);
    next_run.use_ramp = ctrl.ramp_enable && (ramp_slope != '0)
                     && (next_run.peak_step > rpt_pkg::STEP_W'(1));
    ramp_pulses = next_run.use_ramp
                ? (rpt_pkg::COUNT_W+1)'(tri_steps * 32'(ramp_slope)) : '0;
    both_ramps  = {1'b0, ramp_pulses} + {1'b0, ramp_pulses};
    ramp_bad    = both_ramps > (rpt_pkg::COUNT_W+2)'(total_pulse_count);
    next_run.const_pulses = rpt_pkg::COUNT_W'(
                 (rpt_pkg::COUNT_W+2)'(total_pulse_count) - both_ramps);
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------
  logic [rpt_pkg::STEP_W-1:0]        step_n;
  logic [rpt_pkg::COUNT_W-1:0]       left;
  logic                              restart;
  logic                              div_en;
  logic                              pulse_fall;
  logic                              phase;
  logic [ACC_W-1:0]                  div_inc;
  logic                              ev_done;
  logic                              ev_err;
  logic                              last_in_step;
  function automatic logic [rpt_pkg::COUNT_W-1:0] step_pulses(
    input logic [rpt_pkg::SLOPE_W-1:0] slope,
    input logic [rpt_pkg::STEP_W-1:0]  n
  );
    step_pulses = rpt_pkg::COUNT_W'(32'(slope) * 32'(n));
  endfunction
  assign last_in_step = pulse_fall && (left == rpt_pkg::COUNT_W'(1));

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      state    <= rpt_pkg::ST_IDLE;
      run      <= '0;
      step_n   <= '0;
      left     <= '0;
      restart  <= 1'b0;
      err_code <= rpt_pkg::CODE_NORMAL;
      ev_done  <= 1'b0;
      ev_err   <= 1'b0;
    end else begin
      restart <= 1'b0;
      ev_done <= 1'b0;
      ev_err  <= 1'b0;
      unique case (state)
        rpt_pkg::ST_IDLE: begin
          if (start_req) begin
            run     <= next_run;
            restart <= 1'b1;
            if (rate_bad) begin
              err_code <= rpt_pkg::CODE_RATE_ERR;
              ev_err   <= 1'b1;
            end else if (ramp_bad) begin
              err_code <= rpt_pkg::CODE_RAMP_ERR;
              ev_err   <= 1'b1;
            end else if (next_run.use_ramp) begin
              err_code <= rpt_pkg::CODE_NORMAL;
              state    <= rpt_pkg::ST_ACCEL;
              step_n   <= rpt_pkg::STEP_W'(1);
              left     <= step_pulses(ramp_slope, rpt_pkg::STEP_W'(1));
            end else begin
              err_code <= rpt_pkg::CODE_NORMAL;
              state    <= rpt_pkg::ST_CONST;
              step_n   <= next_run.peak_step;
              left     <= total_pulse_count;
            end
          end
        end
        rpt_pkg::ST_ACCEL: begin
          if (pulse_fall) begin
            left <= left - rpt_pkg::COUNT_W'(1);
          end
          if (last_in_step) begin
            restart <= 1'b1;
            if (step_n == run.peak_step - rpt_pkg::STEP_W'(1)) begin
              state  <= rpt_pkg::ST_CONST;
              step_n <= run.peak_step;
              left   <= run.const_pulses;
            end else begin
              step_n <= step_n + rpt_pkg::STEP_W'(1);
              left   <= step_pulses(run.ramp_slope, step_n + rpt_pkg::STEP_W'(1));
            end
          end
        end
        rpt_pkg::ST_CONST: begin
          if (left == '0) begin
            restart <= 1'b1;
            if (run.use_ramp) begin
              state  <= rpt_pkg::ST_DECEL;
              step_n <= run.peak_step - rpt_pkg::STEP_W'(1);
              left   <= step_pulses(run.ramp_slope, run.peak_step - rpt_pkg::STEP_W'(1));
            end else begin
              state <= rpt_pkg::ST_FINISH;
            end
          end else if (pulse_fall) begin
            left <= left - rpt_pkg::COUNT_W'(1);
          end
        end
        rpt_pkg::ST_DECEL: begin
          if (pulse_fall) begin
            left <= left - rpt_pkg::COUNT_W'(1);
          end
          if (last_in_step) begin
            restart <= 1'b1;
            if (step_n == rpt_pkg::STEP_W'(1)) begin
              state <= rpt_pkg::ST_FINISH;
            end else begin
              step_n <= step_n - rpt_pkg::STEP_W'(1);
              left   <= step_pulses(run.ramp_slope, step_n - rpt_pkg::STEP_W'(1));
            end
          end
        end
        rpt_pkg::ST_FINISH: begin
          ev_done <= 1'b1;
          state   <= rpt_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Pulse divider
  // ---------------------------------------------------------------
  assign div_en = ((state == rpt_pkg::ST_ACCEL) || (state == rpt_pkg::ST_CONST)
                || (state == rpt_pkg::ST_DECEL)) && (left != '0) && !restart;
  // Toggle rate is twice the pulse rate; n * 50 pps per step
  assign div_inc = ACC_W'(32'(step_n) * rpt_pkg::STEP_PPS
                 * rpt_pkg::TOGGLES_PER_PULSE);

  rpt_rate_divider #(
    .LIMIT (CLK_HZ),
    .ACC_W (ACC_W)
  ) u_divider (
    .clk_in     (CLK_IN),
    .rst_in     (SYS_RST_IN),
    .restart_in (restart),
    .enable_in  (div_en),
    .inc_in     (div_inc),
    .phase_out  (phase),
    .fall_out   (pulse_fall)
  );

  // ---------------------------------------------------------------
  // Run status and pulse count
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      running   <= 1'b0;
      done      <= 1'b0;
      cur_count <= '0;
    end else begin
      if (start_req) begin
        done      <= 1'b0;
        cur_count <= '0;
      end else if (pulse_fall) begin
        cur_count <= cur_count + rpt_pkg::COUNT_W'(1);
      end
      if (state == rpt_pkg::ST_FINISH) begin
        running <= 1'b0;
        done    <= 1'b1;
      end else if (phase && div_en) begin
        running <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // Driver outputs
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PULSE_OUT     <= 1'b0;
      REV_PULSE_OUT <= 1'b0;
      DIR_OUT       <= 1'b0;
    end else if (run.ctrl.dir_mode) begin
      PULSE_OUT     <= phase && !run.ctrl.direction;
      REV_PULSE_OUT <= phase && run.ctrl.direction;
      DIR_OUT       <= 1'b0;
    end else begin
      PULSE_OUT     <= phase;
      REV_PULSE_OUT <= 1'b0;
      DIR_OUT       <= run.ctrl.direction;
    end
  end

  // ---------------------------------------------------------------
  // Interrupts: sticky, write one to clear, set wins
  // ---------------------------------------------------------------
  logic [rpt_pkg::INT_W-1:0] int_set;
  logic [rpt_pkg::INT_W-1:0] int_clr;
  always_comb begin
    int_set = '0;
    int_set[rpt_pkg::INT_DONE_BIT] = ev_done;
    int_set[rpt_pkg::INT_ERR_BIT]  = ev_err;
    int_clr = (wr_en && PADDR_IN == rpt_pkg::ADDR_INT_STAT)
            ? PWDATA_IN[rpt_pkg::INT_W-1:0] : '0;
  end
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      int_stat <= '0;
      IRQ_OUT  <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
      IRQ_OUT  <= |(((int_stat & ~int_clr) | int_set) & int_mask);
    end
  end

endmodule

// ---- rtl/rpt_pkg.sv ----
// Purpose: Shared constants and types for the ramped pulse train generator
// Assumes: 32-bit APB register bus, one system clock
// Notes:   Register offsets are byte addresses of aligned words

package rpt_pkg;

  // ---------------------------------------------------------------
  // Clock and rate figures
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned STEP_PPS      = 50;
  localparam int unsigned MAX_PPS       = 2000;
  localparam int unsigned TOGGLES_PER_PULSE = 2;
  localparam int unsigned STEP_TIME_MS  = 20;

  localparam int          RATE_W        = 12;
  localparam int          STEP_W        = 6;
  localparam int          SLOPE_W       = 16;
  localparam int          COUNT_W       = 32;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_PEAK_RATE = 8'h04;
  localparam logic [7:0] ADDR_TOTAL     = 8'h08;
  localparam logic [7:0] ADDR_SLOPE     = 8'h0C;
  localparam logic [7:0] ADDR_STATUS    = 8'h10;
  localparam logic [7:0] ADDR_CUR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_INT_STAT  = 8'h18;
  localparam logic [7:0] ADDR_INT_MASK  = 8'h1C;

  // Status field positions
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_RUN_BIT  = 8;
  localparam int STAT_DONE_BIT = 9;

  // Interrupt bits
  localparam int INT_W        = 2;
  localparam int INT_DONE_BIT = 0;
  localparam int INT_ERR_BIT  = 1;

  // Error status codes
  localparam logic [7:0] CODE_NORMAL    = 8'h00;
  localparam logic [7:0] CODE_RATE_ERR  = 8'h02;
  localparam logic [7:0] CODE_RAMP_ERR  = 8'h03;

  // Reset values
  localparam logic [RATE_W-1:0]  RST_PEAK_RATE = 12'h3E8;
  localparam logic [COUNT_W-1:0] RST_TOTAL     = 32'h0000_0000;
  localparam logic [SLOPE_W-1:0] RST_SLOPE     = 16'h0001;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dir_mode;      // 0: pulse + level, 1: separate fwd/rev pulses
    logic direction;     // 0: forward, 1: reverse
    logic ramp_enable;
    logic request;
  } rpt_ctrl_s;

  typedef struct packed {
    rpt_ctrl_s              ctrl;
    logic [STEP_W-1:0]      peak_step;
    logic [SLOPE_W-1:0]     ramp_slope;
    logic [COUNT_W-1:0]     total_pulse_count;
    logic [COUNT_W-1:0]     const_pulses;
    logic                   use_ramp;
  } rpt_run_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACCEL,
    ST_CONST,
    ST_DECEL,
    ST_FINISH
  } rpt_state_e;

endpackage

// ---- rtl/rpt_rate_divider.sv ----
// Purpose: Phase-accumulator divider that turns a pulse rate into a square wave
// Assumes: Increment is twice the wanted pulse rate, limit is the clock rate
// Notes:   Restart clears the phase so each step begins a fresh period

`timescale 1ns/1ps

module rpt_rate_divider #(
  parameter int unsigned LIMIT = 100_000_000,
  parameter int          ACC_W = 32
) (
  // Clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_in,
  // Control
  input  wire logic             restart_in,
  input  wire logic             enable_in,
  input  wire logic [ACC_W-1:0] inc_in,
  // Output
  output logic                  phase_out,
  output logic                  fall_out
);

  localparam logic [ACC_W:0] LIMIT_V = (ACC_W+1)'(LIMIT);

  logic [ACC_W-1:0] acc;
  logic [ACC_W:0]   sum;
  logic             wrap;

  initial begin
    if (LIMIT == 0 || ACC_W < 8) begin
      $error("rpt_rate_divider: unusable LIMIT or ACC_W");
    end
  end

  assign sum  = {1'b0, acc} + {1'b0, inc_in};
  assign wrap = enable_in && (sum >= LIMIT_V);

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= '0;
    end else if (restart_in) begin
      acc <= '0;
    end else if (wrap) begin
      acc <= ACC_W'(sum - LIMIT_V);
    end else if (enable_in) begin
      acc <= ACC_W'(sum);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_out <= 1'b0;
      fall_out  <= 1'b0;
    end else if (restart_in) begin
      phase_out <= 1'b0;
      fall_out  <= 1'b0;
    end else begin
      fall_out <= wrap && phase_out;
      if (wrap) begin
        phase_out <= ~phase_out;
      end
    end
  end

endmodule

// ---- sim/rpt_pulse_train_chk.sv ----
// Purpose: Pin-level checks for the pulse train generator
// Assumes: Zero wait state bus, registered outputs
// Notes:   Bound from the bench top
`timescale 1ns/1ps
module rpt_pulse_train_chk (
  // Clock and reset
  input wire logic        CLK_IN,
  input wire logic        SYS_RST_IN,
  // Bus
  input wire logic        PSEL_IN,
  input wire logic        PENABLE_IN,
  input wire logic        PWRITE_IN,
  input wire logic [7:0]  PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic        PREADY_OUT,
  input wire logic [31:0] PRDATA_OUT,
  input wire logic        PSLVERR_OUT,
  // Driver and interrupt
  input wire logic        PULSE_OUT,
  input wire logic        REV_PULSE_OUT,
  input wire logic        DIR_OUT,
  input wire logic        IRQ_OUT
);
  // --------------------
  // Checks
  // --------------------
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic acc;
  assign acc = PSEL_IN && PENABLE_IN;
  a_ready_high: assert property (PREADY_OUT) else $error("ready low");
  a_bad_addr: assert property (acc && PADDR_IN > 8'h1C |-> PSLVERR_OUT) else $error("no slverr");
  a_bad_rdata: assert property (acc && !PWRITE_IN && PADDR_IN > 8'h1C |-> PRDATA_OUT == '0)
    else $error("unmapped data");
  a_one_line: assert property (!(PULSE_OUT && REV_PULSE_OUT)) else $error("both lines");
  a_rev_nodir: assert property (REV_PULSE_OUT |-> !DIR_OUT) else $error("dir in mode 1");
  a_pulse_width: assert property ($rose(PULSE_OUT) |=> PULSE_OUT [*8]) else $error("glitch");
  a_dir_steady: assert property ($fell(PULSE_OUT) |-> $stable(DIR_OUT)) else $error("dir moved");
  a_irq_masked: assert property (acc && PWRITE_IN && PADDR_IN == 8'h1C && PWDATA_IN == '0
    |-> ##2 !IRQ_OUT) else $error("irq not masked");
endmodule

// ---- sim/rpt_driver_model.sv ----
// Purpose: Motor driver model that counts received pulses
// Assumes: Steps of 50 and 100 pps and a peak of 150 pps
// Notes:   A pulse counts at its fall, sorted by its high time
`timescale 1ns/1ps
module rpt_driver_model #(
  parameter int HZ = 40000
) (
  // Clock, reset and clear
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic clr_in,
  // Driver pins
  input  wire logic pulse_in,
  input  wire logic rev_in,
  input  wire logic dir_in,
  // Tallies
  output int        fwd_out,
  output int        rev_out,
  output int        slow_out,
  output int        mid_out,
  output int        fast_out,
  output logic      dir_out
);
  // --------------------
  // Pulse sorting
  // --------------------
  int   w;
  logic rev_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || clr_in) begin
      {fwd_out, rev_out, slow_out, mid_out, fast_out, w} <= '0;
      dir_out <= 1'b0;
      rev_q <= 1'b0;
    end else if (pulse_in || rev_in) begin
      w <= w + 1;
      rev_q <= rev_in;
      if (w == 0) dir_out <= dir_in;
    end else if (w != 0) begin
      w <= 0;
      if (rev_q) rev_out <= rev_out + 1;
      else fwd_out <= fwd_out + 1;
      if (w * 150 > HZ) slow_out <= slow_out + 1;
      else if (w * 250 > HZ) mid_out <= mid_out + 1;
      else fast_out <= fast_out + 1;
    end
  end
endmodule

// ---- sim/rpt_pulse_train_tb_top.sv ----
// Purpose: Self-checking bench for the pulse train generator
// Assumes: Short clock figure, so a 50 pps pulse lasts 800 cycles
// Notes:   Normal runs use a 150 pps peak, two ramp steps
`timescale 1ns/1ps
module rpt_pulse_train_tb_top;
  // --------------------
  // Bench
  // --------------------
  localparam int unsigned HZ = 40000;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        clr = 1'b0;
  logic [7:0]  paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rdat;
  logic        pready, pslverr, pulse, rev, dir, irq, rerr, m_dir;
  int          errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          m_fwd, m_rev, m_slow, m_mid, m_fast;
  always #5 clk = ~clk;
  rpt_pulse_train #(.CLK_HZ(HZ)) i_dut (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel),
    .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
    .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .PULSE_OUT(pulse),
    .REV_PULSE_OUT(rev), .DIR_OUT(dir), .IRQ_OUT(irq));
  rpt_driver_model #(.HZ(HZ)) i_drv (.clk_in(clk), .rst_in(rst), .clr_in(clr),
    .pulse_in(pulse), .rev_in(rev), .dir_in(dir), .fwd_out(m_fwd), .rev_out(m_rev),
    .slow_out(m_slow), .mid_out(m_mid), .fast_out(m_fast), .dir_out(m_dir));
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [11:0] rate, input logic [7:0] tot, slp, ctl, code);
    int n;
    clr <= 1'b1;
    apb(1'b1, rpt_pkg::ADDR_PEAK_RATE, 32'(rate));
    clr <= 1'b0;
    apb(1'b1, rpt_pkg::ADDR_TOTAL, 32'(tot));
    apb(1'b1, rpt_pkg::ADDR_SLOPE, 32'(slp));
    apb(1'b1, rpt_pkg::ADDR_CTRL, '0);
    apb(1'b1, rpt_pkg::ADDR_CTRL, 32'(ctl));
    n = 0;
    do begin
      apb(1'b0, rpt_pkg::ADDR_STATUS, '0);
      n++;
    end while (rdat[9] !== 1'b1 && rdat[7:0] === 8'h00 && n < 9000);
    chk("status code", 32'(rdat[7:0]), 32'(code));
  endtask
  task automatic t_regs();
    logic [7:0]  a[5] = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h1C};
    logic [11:0] v[5] = '{12'h3E8, 12'h000, 12'h001, 12'h000, 12'h000};
    foreach (a[i]) begin
      apb(1'b0, a[i], '0);
      chk("reset value", rdat, 32'(v[i]));
    end
    apb(1'b0, 8'h20, '0);
    chk("unmapped err", 32'(rerr), 32'h0000_0001);
    apb(1'b1, rpt_pkg::ADDR_STATUS, 32'h0000_0300);
    apb(1'b0, rpt_pkg::ADDR_STATUS, '0);
    chk("status ro", rdat, '0);
  endtask
  task automatic t_errors();
    logic [11:0] bad[4] = '{12'h000, 12'h04B, 12'h802, 12'hFFF};
    apb(1'b1, rpt_pkg::ADDR_INT_MASK, 32'h0000_0003);
    foreach (bad[k]) begin
      run(bad[k], 8'h0A, 8'h01, 8'h03, rpt_pkg::CODE_RATE_ERR);
      repeat (3) @(posedge clk);
      chk("irq raised", 32'(irq), 32'h0000_0001);
      apb(1'b1, rpt_pkg::ADDR_INT_STAT, 32'h0000_0003);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'(irq), '0);
    end
    run(12'h096, 8'h0B, 8'h02, 8'h03, rpt_pkg::CODE_RAMP_ERR);
    chk("no pulses", 32'(m_fwd), '0);
    apb(1'b1, rpt_pkg::ADDR_INT_MASK, '0);
    apb(1'b1, rpt_pkg::ADDR_INT_STAT, 32'h0000_0003);
    apb(1'b1, rpt_pkg::ADDR_INT_MASK, 32'h0000_0001);
  endtask
  task automatic t_runs();
    int t[4][9] = '{'{10, 1, 7, 10, 0, 2, 4, 4, 1}, '{12, 2, 3, 12, 0, 4, 8, 0, 0},
                    '{3, 1, 13, 0, 3, 0, 0, 3, 0}, '{3, 0, 11, 3, 0, 0, 0, 3, 0}};
    foreach (t[i]) begin
      run(12'h096, 8'(t[i][0]), 8'(t[i][1]), 8'(t[i][2]), rpt_pkg::CODE_NORMAL);
      chk("run flags", 32'(rdat[9:8]), 32'h0000_0002);
      chk("fwd pulses", 32'(m_fwd), 32'(t[i][3]));
      chk("rev pulses", 32'(m_rev), 32'(t[i][4]));
      chk("50 pps pulses", 32'(m_slow), 32'(t[i][5]));
      chk("100 pps pulses", 32'(m_mid), 32'(t[i][6]));
      chk("peak pulses", 32'(m_fast), 32'(t[i][7]));
      chk("dir level", 32'(m_dir), 32'(t[i][8]));
      chk("irq done", 32'(irq), 32'h0000_0001);
      apb(1'b0, rpt_pkg::ADDR_CUR_COUNT, '0);
      chk("count", rdat, 32'(t[i][0]));
      apb(1'b1, rpt_pkg::ADDR_INT_STAT, 32'h0000_0003);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      errors++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_errors();
    t_runs();
    final_report();
  end
endmodule
bind rpt_pulse_train rpt_pulse_train_chk i_chk (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PWDATA_IN(PWDATA_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT),
  .PSLVERR_OUT(PSLVERR_OUT), .PULSE_OUT(PULSE_OUT), .REV_PULSE_OUT(REV_PULSE_OUT),
  .DIR_OUT(DIR_OUT), .IRQ_OUT(IRQ_OUT));
